// [hw/prd_apb_regs.v]
// apb slave holding the reference selection and status registers
`include "prd_consts.vh"

module prd_apb_regs (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // register contents
  input wire [3:0] status,
  output reg [3:0] ref_sel_reg
);

  wire setup = psel && !penable;
  wire done = psel && penable && pready;
  wire hit_sel = (paddr[9:2] == `PRD_IDX_REF_SEL) && (paddr[31:10] == 22'h000000);
  wire hit_st = (paddr[9:2] == `PRD_IDX_STATUS) && (paddr[31:10] == 22'h000000);
  wire aligned = (paddr[1:0] == 2'h0);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_sel_reg <= `PRD_SEL_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
      if (setup) begin
        pslverr <= !aligned || !(hit_sel || hit_st);
        if (hit_sel && aligned) begin
          prdata <= {28'h0000000, ref_sel_reg};
        end else if (hit_st && aligned) begin
          prdata <= {28'h0000000, status};
        end else begin
          prdata <= 32'h00000000;
        end
      end
      // status is read only, writes to it are ignored
      if (done && pwrite && hit_sel && aligned) begin
        ref_sel_reg <= pwdata[3:0];
      end
    end
  end

endmodule // prd_apb_regs

// [hw/prd_consts.vh]
// constants of the pll reference divider
`ifndef PRD_CONSTS_VH
`define PRD_CONSTS_VH

// ****************************************
// clocks
// ****************************************
`define PRD_XTAL_HZ 4500000
`define PRD_CLK_HZ 250000000

// ****************************************
// register map (index, byte address = 4 * index)
// ****************************************
`define PRD_IDX_REF_SEL 8'h11
`define PRD_IDX_STATUS 8'h12

// ****************************************
// selection field
// ****************************************
`define PRD_SEL_RESET 4'hf
`define PRD_SEL_DISABLE 4'hf
`define PRD_SEL_BAD_A 4'hb
`define PRD_SEL_BAD_B 4'he

// ****************************************
// status register bit positions
// ****************************************
`define PRD_ST_DISABLED 0
`define PRD_ST_TUNER_EN 1
`define PRD_ST_BAD_SEL 2
`define PRD_ST_REF_LEVEL 3

// ****************************************
// reference frequencies in hz
// ****************************************
`define PRD_FR_1K 1000
`define PRD_FR_1K25 1250
`define PRD_FR_2K5 2500
`define PRD_FR_3K 3000
`define PRD_FR_5K 5000
`define PRD_FR_6K25 6250
`define PRD_FR_9K 9000
`define PRD_FR_10K 10000
`define PRD_FR_12K5 12500
`define PRD_FR_18K 18000
`define PRD_FR_20K 20000
`define PRD_FR_25K 25000
`define PRD_FR_50K 50000

// ****************************************
// widths
// ****************************************
`define PRD_DIV_W 13
`define PRD_SYNC_STAGES 3

`endif

// [hw/prd_ref_divider.v]
// reference counter dividing crystal ticks by a selectable ratio
`include "prd_consts.vh"

module prd_ref_divider (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // control
  input wire xtal_tick,
  input wire run,
  input wire [12:0] div,
  // output
  output reg ref_out
);

  reg [12:0] cnt_reg;
  reg [12:0] cnt_next;
  wire [12:0] last = div - 13'h0001;
  wire [12:0] half = {1'b0, div[12:1]};

  always @* begin
    if (cnt_reg >= last) begin
      cnt_next = 13'h0000;
    end else begin
      cnt_next = cnt_reg + 13'h0001;
    end
  end

  // an odd ratio gives a high phase one crystal tick shorter than the low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 13'h0000;
      ref_out <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        // parked on the last count so the first tick after a start opens a full high phase
        cnt_reg <= last;
        ref_out <= 1'b0;
      end else if (xtal_tick) begin
        cnt_reg <= cnt_next;
        ref_out <= (cnt_next < half);
      end
    end
  end

endmodule // prd_ref_divider

// [hw/prd_top.v]
// pll reference frequency generator with selection register and disable control
//
// Behaviour
// - reference is an integer division of the 4.5 mhz crystal clock
// - thirteen reference frequencies from 1 khz up to 50 khz are offered
// - 4-bit read/write selection at index 11h, reset to all ones
// - selection codes decode to frequencies; 1011, 1110 prohibited; 1111 disables
// - disable code pulls down both oscillator input pins
// - disable code floats both error-output pins
// - synthesizer runs only while tuner enable pin is high
// - when disabled, reference, divider and phase comparator outputs stop
`include "prd_consts.vh"

module prd_top (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // pins from outside
  input wire xtal_clk_in,
  input wire tuner_en_in,
  // phase comparator requests, active low, same clock
  input wire up_req_n,
  input wire down_req_n,
  // input selection from the mode register, high band picked when set
  input wire band_high_sel,
  input wire band_pins_off,
  // oscillator input pull-downs
  output reg osc_input_high_band_pd,
  output reg osc_input_low_band_pd,
  // error outputs
  output reg error_out_pin_1_o,
  output reg error_out_pin_1_oe,
  output reg error_out_pin_0_o,
  output reg error_out_pin_0_oe,
  // to the synthesizer
  output reg reference_frequency,
  output reg synth_stop,
  output reg [3:0] ref_sel_bits
);

  // ****************************************
  // divisor decode
  // ****************************************
  // ratios are worked out in integer arithmetic, then cut to the counter width
  localparam integer RATIO_1K = `PRD_XTAL_HZ / `PRD_FR_1K;
  localparam integer RATIO_1K25 = `PRD_XTAL_HZ / `PRD_FR_1K25;
  localparam integer RATIO_2K5 = `PRD_XTAL_HZ / `PRD_FR_2K5;
  localparam integer RATIO_3K = `PRD_XTAL_HZ / `PRD_FR_3K;
  localparam integer RATIO_5K = `PRD_XTAL_HZ / `PRD_FR_5K;
  localparam integer RATIO_6K25 = `PRD_XTAL_HZ / `PRD_FR_6K25;
  localparam integer RATIO_9K = `PRD_XTAL_HZ / `PRD_FR_9K;
  localparam integer RATIO_10K = `PRD_XTAL_HZ / `PRD_FR_10K;
  localparam integer RATIO_12K5 = `PRD_XTAL_HZ / `PRD_FR_12K5;
  localparam integer RATIO_18K = `PRD_XTAL_HZ / `PRD_FR_18K;
  localparam integer RATIO_20K = `PRD_XTAL_HZ / `PRD_FR_20K;
  localparam integer RATIO_25K = `PRD_XTAL_HZ / `PRD_FR_25K;
  localparam integer RATIO_50K = `PRD_XTAL_HZ / `PRD_FR_50K;
  localparam [12:0] DIV_1K = RATIO_1K[12:0];
  localparam [12:0] DIV_1K25 = RATIO_1K25[12:0];
  localparam [12:0] DIV_2K5 = RATIO_2K5[12:0];
  localparam [12:0] DIV_3K = RATIO_3K[12:0];
  localparam [12:0] DIV_5K = RATIO_5K[12:0];
  localparam [12:0] DIV_6K25 = RATIO_6K25[12:0];
  localparam [12:0] DIV_9K = RATIO_9K[12:0];
  localparam [12:0] DIV_10K = RATIO_10K[12:0];
  localparam [12:0] DIV_12K5 = RATIO_12K5[12:0];
  localparam [12:0] DIV_18K = RATIO_18K[12:0];
  localparam [12:0] DIV_20K = RATIO_20K[12:0];
  localparam [12:0] DIV_25K = RATIO_25K[12:0];
  localparam [12:0] DIV_50K = RATIO_50K[12:0];
  localparam [12:0] DIV_NONE = 13'h0000;

  // zero marks a code with no frequency behind it
  function [12:0] sel_to_div;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: sel_to_div = DIV_1K25;
        4'h1: sel_to_div = DIV_2K5;
        4'h2: sel_to_div = DIV_5K;
        4'h3: sel_to_div = DIV_10K;
        4'h4: sel_to_div = DIV_6K25;
        4'h5: sel_to_div = DIV_12K5;
        4'h6: sel_to_div = DIV_25K;
        4'h7: sel_to_div = DIV_50K;
        4'h8: sel_to_div = DIV_3K;
        4'h9: sel_to_div = DIV_9K;
        4'ha: sel_to_div = DIV_18K;
        4'hc: sel_to_div = DIV_1K;
        4'hd: sel_to_div = DIV_20K;
        default: sel_to_div = DIV_NONE;
      endcase
    end
  endfunction

  function is_prohibited;
    input [3:0] sel;
    begin
      is_prohibited = (sel == `PRD_SEL_BAD_A) || (sel == `PRD_SEL_BAD_B);
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // pin order inside the synchroniser bank
  localparam integer PIN_XTAL = 0;
  localparam integer PIN_TUNER = 1;
  localparam integer PIN_COUNT = 2;

  wire [PIN_COUNT-1:0] pin_raw = {tuner_en_in, xtal_clk_in};
  wire [PIN_COUNT-1:0] pin_level;

  // the crystal must hold each level for two clk edges, or ticks are lost
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
      reg [`PRD_SYNC_STAGES-1:0] stage_reg;
      reg level_reg;
      // a change counts only once stages two and three agree
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage_reg <= 3'h0;
          level_reg <= 1'b0;
        end else if (clk_en) begin
          stage_reg <= {stage_reg[1:0], pin_raw[gi]};
          if (stage_reg[2] == stage_reg[1]) begin
            level_reg <= stage_reg[2];
          end
        end
      end
      assign pin_level[gi] = level_reg;
    end
  endgenerate

  wire xtal_level = pin_level[PIN_XTAL];
  wire tuner_en = pin_level[PIN_TUNER];

  // ****************************************
  // crystal edge detect
  // ****************************************
  // only rising crystal edges count, so the divider sees whole crystal periods
  reg xtal_prev_reg;
  wire xtal_tick = xtal_level && !xtal_prev_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xtal_prev_reg <= 1'b0;
    end else if (clk_en) begin
      xtal_prev_reg <= xtal_level;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  wire [3:0] sel_reg;
  reg [3:0] status;

  prd_apb_regs u_regs (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status(status),
    .ref_sel_reg(sel_reg)
  );

  // ****************************************
  // disable decision
  // ****************************************
  // the selection survives a low tuner enable, so the old setting
  // comes back when the pin rises again
  wire sel_disable = (sel_reg == `PRD_SEL_DISABLE);
  wire synth_off = sel_disable || !tuner_en;
  wire [12:0] div = sel_to_div(sel_reg);
  wire bad_sel = is_prohibited(sel_reg);
  // a prohibited code keeps the pins alive but gives no reference
  wire ref_run = !synth_off && (div != DIV_NONE);
  wire ref_level;

  prd_ref_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .xtal_tick(xtal_tick),
    .run(ref_run),
    .div(div),
    .ref_out(ref_level)
  );

  // ****************************************
  // status
  // ****************************************
  always @* begin
    status = 4'h0;
    status[`PRD_ST_DISABLED] = synth_off;
    status[`PRD_ST_TUNER_EN] = tuner_en;
    status[`PRD_ST_BAD_SEL] = bad_sel;
    status[`PRD_ST_REF_LEVEL] = ref_level;
  end

  // ****************************************
  // charge pump drive
  // ****************************************
  // up request drives low, down request drives high, none floats
  // both requests at once cancel, so the pins float rather than fight
  wire up_act = !up_req_n;
  wire dn_act = !down_req_n;
  reg pump_drive;
  reg pump_level;

  always @* begin
    pump_drive = 1'b0;
    pump_level = 1'b0;
    if (synth_off) begin
      pump_drive = 1'b0;
    end else if (up_act && !dn_act) begin
      pump_drive = 1'b1;
      pump_level = 1'b0;
    end else if (dn_act && !up_act) begin
      pump_drive = 1'b1;
      pump_level = 1'b1;
    end
  end

  // ****************************************
  // oscillator pull-downs
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_input_high_band_pd <= 1'b1;
      osc_input_low_band_pd <= 1'b1;
    end else if (clk_en) begin
      if (synth_off || band_pins_off) begin
        osc_input_high_band_pd <= 1'b1;
        osc_input_low_band_pd <= 1'b1;
      end else begin
        osc_input_high_band_pd <= !band_high_sel;
        osc_input_low_band_pd <= band_high_sel;
      end
    end
  end

  // ****************************************
  // error pins
  // ****************************************
  // both pins carry the same drive so either can feed the loop filter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      error_out_pin_1_o <= 1'b0;
      error_out_pin_1_oe <= 1'b0;
      error_out_pin_0_o <= 1'b0;
      error_out_pin_0_oe <= 1'b0;
    end else if (clk_en) begin
      error_out_pin_1_o <= pump_level;
      error_out_pin_1_oe <= pump_drive;
      error_out_pin_0_o <= pump_level;
      error_out_pin_0_oe <= pump_drive;
    end
  end

  // ****************************************
  // synthesizer outputs
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reference_frequency <= 1'b0;
      synth_stop <= 1'b1;
      ref_sel_bits <= `PRD_SEL_RESET;
    end else if (clk_en) begin
      reference_frequency <= ref_level;
      synth_stop <= synth_off;
      ref_sel_bits <= sel_reg;
    end
  end

endmodule // prd_top

// [tb/prd_asserts.sv]
// concurrent checks on the reference divider ports
module prd_asserts (
  // clock and reset
  input wire clk,
  input wire resetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  // pins
  input wire osc_input_high_band_pd,
  input wire osc_input_low_band_pd,
  input wire error_out_pin_1_o,
  input wire error_out_pin_1_oe,
  input wire error_out_pin_0_o,
  input wire error_out_pin_0_oe,
  input wire reference_frequency,
  input wire synth_stop,
  input wire [3:0] ref_sel_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // three cycles of a code absorb the output register latency
  wire off = ref_sel_bits == 4'hf;
  wire bad = ref_sel_bits == 4'hb || ref_sel_bits == 4'he;
  chk_off_pulled: assert property (off [*3] |-> osc_input_high_band_pd && osc_input_low_band_pd)
    else $error("pull-downs missing");
  chk_off_float: assert property (off [*3] |-> !error_out_pin_1_oe && !error_out_pin_0_oe)
    else $error("error pins driven");
  chk_off_ref: assert property (off [*3] |-> !reference_frequency)
    else $error("reference runs");
  chk_off_stop: assert property (off [*3] |-> synth_stop)
    else $error("stop missing");
  chk_bad_ref: assert property (bad [*3] |-> !reference_frequency)
    else $error("reference on bad code");
  chk_reset_sel: assert property ($rose(resetn) |-> ref_sel_bits == 4'hf)
    else $error("selection reset wrong");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready timing wrong");
  chk_ref_run: assert property ($rose(reference_frequency) |-> !$past(synth_stop) && !$past(off))
    else $error("reference while stopped");
  chk_pins_same: assert property (error_out_pin_1_oe |-> error_out_pin_0_oe
    && error_out_pin_1_o == error_out_pin_0_o)
    else $error("error pins differ");
endmodule // prd_asserts

bind prd_top prd_asserts chk_u (.clk, .resetn, .psel, .penable, .pready,
  .osc_input_high_band_pd, .osc_input_low_band_pd, .error_out_pin_1_o, .error_out_pin_1_oe,
  .error_out_pin_0_o, .error_out_pin_0_oe, .reference_frequency, .synth_stop, .ref_sel_bits);

// [tb/prd_far_end.sv]
// far-side model driving the phase comparator requests
module prd_far_end (
  // clock and reset
  input wire clk,
  input wire resetn,
  // bit0 asks up, bit1 asks down
  input wire [1:0] mode,
  // requests, active low
  output logic up_req_n,
  output logic down_req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_req_n <= 1'b1;
      down_req_n <= 1'b1;
    end else begin
      up_req_n <= !mode[0];
      down_req_n <= !mode[1];
    end
  end
endmodule // prd_far_end

// [tb/testbench.sv]
// self-checking bench for the reference divider
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic xtal_clk_in = 0, tuner_en_in = 0, band_high_sel = 0, band_pins_off = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd;
  logic [1:0] mode = 0;
  wire [31:0] prdata;
  wire pready, pslverr, up_req_n, down_req_n, osc_input_high_band_pd, osc_input_low_band_pd;
  wire error_out_pin_1_o, error_out_pin_1_oe, error_out_pin_0_o, error_out_pin_0_oe;
  wire reference_frequency, synth_stop;
  wire [3:0] ref_sel_bits;
  wire [6:0] pins = {osc_input_high_band_pd, osc_input_low_band_pd, error_out_pin_1_oe,
    error_out_pin_0_oe, error_out_pin_1_o, error_out_pin_0_o, synth_stop};
  int miscompares = 0, checks_done = 0, cycles = 0, hi;
  logic [3:0] code [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13};
  int fr [13] = '{1250, 2500, 5000, 10000, 6250, 12500, 25000, 50000, 3000, 9000, 18000,
    1000, 20000};
  always #2 clk = ~clk;
  // crystal sped up so every ratio fits the run; each edge lands 1 ns before a clk rise
  initial begin
    #1;
    forever #8 xtal_clk_in = ~xtal_clk_in;
  end
  prd_top dut_u (.clk, .resetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .xtal_clk_in, .tuner_en_in, .up_req_n, .down_req_n, .band_high_sel,
    .band_pins_off, .osc_input_high_band_pd, .osc_input_low_band_pd, .error_out_pin_1_o,
    .error_out_pin_1_oe, .error_out_pin_0_o, .error_out_pin_0_oe, .reference_frequency,
    .synth_stop, .ref_sel_bits);
  prd_far_end far_u (.clk, .resetn, .mode, .up_req_n, .down_req_n);
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    chk(pins, 7'h61);
    resetn <= 1;
    apb(0, 32'h44, 0);
    chk(rd, 32'hf);
    tuner_en_in <= 1;
    for (int i = 0; i < 13; i++) begin
      // a prohibited code parks the counter, so each row opens a fresh period
      apb(1, 32'h44, 32'hb);
      apb(1, 32'h44, code[i]);
      @(posedge reference_frequency);
      hi = 0;
      while (reference_frequency === 1'b1) begin
        @(posedge xtal_clk_in or negedge reference_frequency);
        if (reference_frequency === 1'b1) hi++;
      end
      chk(hi, 4500000 / fr[i] / 2);
      apb(0, 32'h44, 0);
      chk(rd, code[i]);
      $display("row %0d done", i);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1, 32'h44, i ? 32'he : 32'hb);
      repeat (5) @(posedge clk);
      hi = 0;
      repeat (3000) @(posedge clk) hi += reference_frequency !== 1'b0;
      chk(hi, 0);
    end
    $display("prohibited codes done");
    apb(1, 32'h44, 9);
    mode <= 1;
    repeat (10) @(posedge clk);
    chk(pins, 7'h58);
    mode <= 2;
    band_high_sel <= 1;
    repeat (10) @(posedge clk);
    chk(pins, 7'h3e);
    clk_en <= 0;
    mode <= 1;
    @(posedge clk);
    hi = reference_frequency;
    repeat (1200) @(posedge clk);
    chk(pins, 7'h3e);
    chk(reference_frequency, hi);
    clk_en <= 1;
    band_pins_off <= 1;
    repeat (10) @(posedge clk);
    chk(pins, 7'h78);
    band_pins_off <= 0;
    $display("freeze and band off done");
    apb(1, 32'h44, 32'hf);
    repeat (10) @(posedge clk);
    chk(pins, 7'h61);
    apb(1, 32'h44, 9);
    repeat (10) @(posedge clk);
    chk(ref_sel_bits, 4'h9);
    tuner_en_in <= 0;
    repeat (20) @(posedge clk);
    chk(pins, 7'h61);
    chk(reference_frequency, 0);
    apb(0, 32'h44, 0);
    chk(rd, 9);
    apb(0, 32'h48, 0);
    chk(rd, 32'h1);
    apb(0, 32'h80, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("pins and bus done");
    complete_run;
  end
endmodule // testbench
